// File: hdl/mem_event_pkg.sv
// Package: register map, field layout and bus types of the memory event registers
package mem_event_pkg;
   localparam logic [7:0] NMI_CTRL_OFF = 8'h14;
   localparam logic [7:0] NMI_STAT_OFF = 8'h18;
   localparam logic [7:0] NMI_CLR_OFF = 8'h1c;
   localparam logic [7:0] NMI_SET_OFF = 8'h20;
   localparam logic [7:0] IRQ_EN_OFF = 8'h24;
   localparam logic [7:0] IRQ_STAT_OFF = 8'h28;
   localparam logic [7:0] IRQ_CLR_OFF = 8'h2c;
   localparam logic [7:0] IRQ_SET_OFF = 8'h30;
   localparam logic [7:0] MERR_STAT_OFF = 8'h34;
   localparam logic [7:0] MERR_CLR_OFF = 8'h38;
   localparam logic [7:0] MERR_SET_OFF = 8'h3c;
   localparam logic [7:0] EVT_STAT_OFF = 8'h40;
   localparam logic [7:0] EVT_MASK_OFF = 8'h44;
   localparam int NMI_W = 9;
   localparam int IRQ_W = 2;
   localparam logic [31:0] MERR_MASK = 32'h0007_07ff;
   localparam logic [31:0] RESET_VAL = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;
endpackage : mem_event_pkg

// File: hdl/mem_event_regs.sv
// Memory controller event, NMI and error flag registers behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers is this design's own decision.
module mem_event_regs
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire mem_event_pkg::axil_req_t axi_req,
   output mem_event_pkg::axil_rsp_t axi_rsp,
   input wire logic [mem_event_pkg::NMI_W-1:0] nmi_event,
   input wire logic [mem_event_pkg::IRQ_W-1:0] flash_done,
   input wire logic [31:0] mem_error_event,
   output logic nmi_req,
   output logic [mem_event_pkg::IRQ_W-1:0] flash_done_irq,
   output logic event_irq
);
   localparam int NW = mem_event_pkg::NMI_W;
   localparam int IW = mem_event_pkg::IRQ_W;

   // Bus holding registers
   logic aw_hold_q;
   logic [7:0] aw_addr_q;
   logic w_hold_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // Architectural state
   logic [NW-1:0] nmi_enable_q;
   logic [NW-1:0] nmi_pending_q;
   logic [IW-1:0] irq_enable_q;
   logic [IW-1:0] irq_status_q;
   logic [31:0] mem_error_status_q;
   logic [1:0] evt_status_q;
   logic [1:0] evt_mask_q;
   logic nmi_req_q;
   logic [IW-1:0] done_irq_q;
   logic event_irq_q;

   // Write strobes: decoded from the held address and data, never stored, acted on only in the wr_fire cycle, so trigger bits self-clear
   logic wr_fire;
   logic [31:0] wr_data;
   logic [NW-1:0] nmi_set_p;
   logic [NW-1:0] nmi_clr_p;
   logic [IW-1:0] irq_set_p;
   logic [IW-1:0] irq_clr_p;
   logic [31:0] merr_set_p;
   logic [31:0] merr_clr_p;
   logic wr_nmi_ctrl;
   logic wr_irq_en;
   logic wr_evt_mask;
   logic wr_hit;
   logic rd_fire;
   logic rd_evt_stat;

   assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   // Only full-lane data counts for lanes with strobe set
   assign wr_data = w_data_q & {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                                {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

   // Write address decode
   always_comb
   begin
      nmi_set_p = '0;
      nmi_clr_p = '0;
      irq_set_p = '0;
      irq_clr_p = '0;
      merr_set_p = '0;
      merr_clr_p = '0;
      wr_nmi_ctrl = 1'b0;
      wr_irq_en = 1'b0;
      wr_evt_mask = 1'b0;
      wr_hit = 1'b1;
      if (aw_addr_q == mem_event_pkg::NMI_SET_OFF)
         nmi_set_p = wr_data[NW-1:0];
      else if (aw_addr_q == mem_event_pkg::NMI_CLR_OFF)
         nmi_clr_p = wr_data[NW-1:0];
      else if (aw_addr_q == mem_event_pkg::NMI_CTRL_OFF)
         wr_nmi_ctrl = 1'b1;
      else if (aw_addr_q == mem_event_pkg::IRQ_EN_OFF)
         wr_irq_en = 1'b1;
      else if (aw_addr_q == mem_event_pkg::IRQ_CLR_OFF)
         irq_clr_p = wr_data[IW-1:0];
      else if (aw_addr_q == mem_event_pkg::IRQ_SET_OFF)
         irq_set_p = wr_data[IW-1:0];
      else if (aw_addr_q == mem_event_pkg::MERR_CLR_OFF)
         merr_clr_p = wr_data & mem_event_pkg::MERR_MASK;
      else if (aw_addr_q == mem_event_pkg::MERR_SET_OFF)
         merr_set_p = wr_data & mem_event_pkg::MERR_MASK;
      else if (aw_addr_q == mem_event_pkg::EVT_MASK_OFF)
         wr_evt_mask = 1'b1;
      else if (aw_addr_q == mem_event_pkg::IRQ_STAT_OFF ||
               aw_addr_q == mem_event_pkg::MERR_STAT_OFF ||
               aw_addr_q == mem_event_pkg::NMI_STAT_OFF ||
               aw_addr_q == mem_event_pkg::EVT_STAT_OFF)
         wr_hit = 1'b1; // Read-only: write ignored, still OKAY
      else
         wr_hit = 1'b0;
   end

   // Address and data capture in either order
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         aw_hold_q <= 1'b0;
         aw_addr_q <= '0;
         w_hold_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end
      else
      begin
         if (axi_req.awvalid && !aw_hold_q)
         begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= {axi_req.awaddr[7:2], 2'b00};
         end
         else if (wr_fire)
            aw_hold_q <= 1'b0;
         if (axi_req.wvalid && !w_hold_q)
         begin
            w_hold_q <= 1'b1;
            w_data_q <= axi_req.wdata;
            w_strb_q <= axi_req.wstrb;
         end
         else if (wr_fire)
            w_hold_q <= 1'b0;
      end
   end

   // Write response
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= mem_event_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? mem_event_pkg::RESP_OKAY : mem_event_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && axi_req.bready)
         bvalid_q <= 1'b0;
   end

   assign rd_fire = axi_req.arvalid && !rvalid_q;
   assign rd_evt_stat = rd_fire && ({axi_req.araddr[7:2], 2'b00} == mem_event_pkg::EVT_STAT_OFF);

   // Read path; reserved bits come back zero because the fields are zero-extended and the error status is masked with MERR_MASK
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= mem_event_pkg::RESP_OKAY;
      end
      else if (rd_fire)
      begin
         logic [7:0] ra;
         ra = {axi_req.araddr[7:2], 2'b00};
         rvalid_q <= 1'b1;
         rresp_q <= mem_event_pkg::RESP_OKAY;
         if (ra == mem_event_pkg::NMI_CTRL_OFF)
            rdata_q <= 32'(nmi_enable_q);
         else if (ra == mem_event_pkg::NMI_STAT_OFF)
            rdata_q <= 32'(nmi_pending_q);
         else if (ra == mem_event_pkg::IRQ_EN_OFF)
            rdata_q <= 32'(irq_enable_q);
         else if (ra == mem_event_pkg::IRQ_STAT_OFF)
            rdata_q <= 32'(irq_status_q);
         else if (ra == mem_event_pkg::MERR_STAT_OFF)
            rdata_q <= mem_error_status_q & mem_event_pkg::MERR_MASK;
         else if (ra == mem_event_pkg::EVT_STAT_OFF)
            rdata_q <= 32'(evt_status_q);
         else if (ra == mem_event_pkg::EVT_MASK_OFF)
            rdata_q <= 32'(evt_mask_q);
         else if (ra == mem_event_pkg::NMI_SET_OFF || ra == mem_event_pkg::NMI_CLR_OFF ||
                  ra == mem_event_pkg::IRQ_CLR_OFF || ra == mem_event_pkg::IRQ_SET_OFF ||
                  ra == mem_event_pkg::MERR_CLR_OFF || ra == mem_event_pkg::MERR_SET_OFF)
            rdata_q <= mem_event_pkg::RESET_VAL;
         else
         begin
            rdata_q <= '0;
            rresp_q <= mem_event_pkg::RESP_SLVERR;
         end
      end
      else if (rvalid_q && axi_req.rready)
         rvalid_q <= 1'b0;
   end

   // Software-written enables and mask
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         nmi_enable_q <= '0;
         irq_enable_q <= '0;
         evt_mask_q <= '0;
      end
      else if (wr_fire)
      begin
         if (wr_nmi_ctrl)
            nmi_enable_q <= wr_data[NW-1:0];
         if (wr_irq_en)
            irq_enable_q <= wr_data[IW-1:0];
         if (wr_evt_mask)
            evt_mask_q <= wr_data[1:0];
      end
   end

   // Sticky flags: set beats clear so an event in the clear cycle survives
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         nmi_pending_q <= '0;
         irq_status_q <= '0;
         mem_error_status_q <= '0;
      end
      else
      begin
         nmi_pending_q <= (nmi_pending_q & ~(wr_fire ? nmi_clr_p : '0))
                          | nmi_event | (wr_fire ? nmi_set_p : '0);
         irq_status_q <= (irq_status_q & ~(wr_fire ? irq_clr_p : '0))
                         | flash_done | (wr_fire ? irq_set_p : '0);
         mem_error_status_q <= ((mem_error_status_q & ~(wr_fire ? merr_clr_p : '0))
                               | mem_error_event | (wr_fire ? merr_set_p : '0))
                               & mem_event_pkg::MERR_MASK;
      end
   end

   // Summary events: bit 0 any new error, bit 1 any new done; read clears
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         evt_status_q <= '0;
      else
         evt_status_q <= (rd_evt_stat ? 2'b00 : evt_status_q)
                         | {|flash_done, |(mem_error_event & mem_event_pkg::MERR_MASK)};
   end

   // Registered outputs: one cycle behind the flags
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         nmi_req_q <= 1'b0;
         done_irq_q <= '0;
         event_irq_q <= 1'b0;
      end
      else
      begin
         nmi_req_q <= |(nmi_pending_q & nmi_enable_q);
         done_irq_q <= irq_status_q & irq_enable_q;
         event_irq_q <= |(evt_status_q & evt_mask_q);
      end
   end

   assign nmi_req = nmi_req_q;
   assign flash_done_irq = done_irq_q;
   assign event_irq = event_irq_q;
   // Response struct filled in one process so the port variable has a single driver
   always_comb
   begin
      axi_rsp.awready = !aw_hold_q;
      axi_rsp.wready = !w_hold_q;
      axi_rsp.bvalid = bvalid_q;
      axi_rsp.bresp = bresp_q;
      axi_rsp.arready = !rvalid_q;
      axi_rsp.rvalid = rvalid_q;
      axi_rsp.rdata = rdata_q;
      axi_rsp.rresp = rresp_q;
   end

   // Checks
   a_nmi_set_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
      wr_fire && nmi_set_p[0] |=> nmi_pending_q[0])
      else $error("nmi set did not raise flag");
   a_nmi_set_hi: assert property (@(posedge core_clk) disable iff (sys_rst)
      wr_fire && nmi_set_p[8] |=> nmi_pending_q[8])
      else $error("stack nmi set lost");
   a_trig_reads_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      rd_fire && {axi_req.araddr[7:2], 2'b00} == mem_event_pkg::NMI_SET_OFF |=> rdata_q == '0)
      else $error("trigger register read not zero");
   a_irq_res_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      rvalid_q |-> rdata_q[31:19] == '0)
      else $error("reserved bits not zero");
   a_irq_en_write: assert property (@(posedge core_clk) disable iff (sys_rst)
      wr_fire && wr_irq_en |=> irq_enable_q == $past(wr_data[IW-1:0]))
      else $error("enable write lost");
   a_done_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
      flash_done[0] |=> irq_status_q[0])
      else $error("done flag not set");
   a_flag_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
      irq_status_q[1] && !(wr_fire && irq_clr_p[1]) |=> irq_status_q[1])
      else $error("done flag dropped");
   a_irq_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      wr_fire && irq_clr_p[0] && !irq_set_p[0] && !flash_done[0] |=> !irq_status_q[0])
      else $error("clear failed");
   a_irq_set: assert property (@(posedge core_clk) disable iff (sys_rst)
      wr_fire && irq_set_p[1] |=> irq_status_q[1])
      else $error("set failed");
   a_merr_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      wr_fire && merr_clr_p[16] && !merr_set_p[16] && !mem_error_event[16]
      |=> !mem_error_status_q[16])
      else $error("error clear failed");
   a_merr_set: assert property (@(posedge core_clk) disable iff (sys_rst)
      wr_fire && merr_set_p[10] |=> mem_error_status_q[10])
      else $error("error set failed");
   a_done_irq_out: assert property (@(posedge core_clk) disable iff (sys_rst)
      irq_status_q[0] && irq_enable_q[0] |=> flash_done_irq[0] ##1 1'b1)
      else $error("done irq missing");
   a_nmi_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      nmi_pending_q == '0 || nmi_enable_q == '0 |=> !nmi_req)
      else $error("nmi not gated");

   c_nmi_fire: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(nmi_req));
   c_done_irq: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(flash_done_irq[1]));
   c_set_clear: cover property (@(posedge core_clk) disable iff (sys_rst)
      wr_fire && merr_set_p != '0 ##[1:20] wr_fire && merr_clr_p != '0);
endmodule : mem_event_regs

// File: sim/mem_event_regs_test.sv
// Self-checking bench for the memory event register block over AXI4-Lite
module mem_event_regs_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   mem_event_pkg::axil_req_t axi_req = '0;
   mem_event_pkg::axil_rsp_t axi_rsp;
   logic [mem_event_pkg::NMI_W-1:0] nmi_event = '0;
   logic [mem_event_pkg::IRQ_W-1:0] flash_done = '0;
   logic [31:0] mem_error_event = '0;
   logic nmi_req;
   logic [mem_event_pkg::IRQ_W-1:0] flash_done_irq;
   logic event_irq;
   logic [31:0] d;
   logic [1:0] r;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;

   always #2.5 core_clk = ~core_clk;

   mem_event_regs i_dut
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .axi_req(axi_req),
      .axi_rsp(axi_rsp),
      .nmi_event(nmi_event),
      .flash_done(flash_done),
      .mem_error_event(mem_error_event),
      .nmi_req(nmi_req),
      .flash_done_irq(flash_done_irq),
      .event_irq(event_irq)
   );

   // Hang guard; the whole sequence needs well under a thousand cycles
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         fails = fails + 1;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask : chk

   // Write with address and data offered together; each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] resp);
      logic aw_open;
      logic w_open;
      @(posedge core_clk);
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= wd;
      axi_req.wstrb <= 4'hf;
      axi_req.bready <= 1'b1;
      aw_open = 1'b1;
      w_open = 1'b1;
      resp = 2'h3;
      for (int n = 0; n < 50; n++)
      begin
         @(posedge core_clk);
         if (aw_open && axi_rsp.awready)
         begin
            axi_req.awvalid <= 1'b0;
            aw_open = 1'b0;
         end
         if (w_open && axi_rsp.wready)
         begin
            axi_req.wvalid <= 1'b0;
            w_open = 1'b0;
         end
         if (axi_rsp.bvalid)
         begin
            resp = axi_rsp.bresp;
            break;
         end
      end
      axi_req.bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] rdat, output logic [1:0] resp);
      logic ar_open;
      @(posedge core_clk);
      axi_req.arvalid <= 1'b1;
      axi_req.araddr <= a;
      axi_req.rready <= 1'b1;
      ar_open = 1'b1;
      rdat = 32'hdead_beef;
      resp = 2'h3;
      for (int n = 0; n < 50; n++)
      begin
         @(posedge core_clk);
         if (ar_open && axi_rsp.arready)
         begin
            axi_req.arvalid <= 1'b0;
            ar_open = 1'b0;
         end
         if (axi_rsp.rvalid)
         begin
            rdat = axi_rsp.rdata;
            resp = axi_rsp.rresp;
            break;
         end
      end
      axi_req.rready <= 1'b0;
   endtask : rd

   task automatic wc(input logic [7:0] a, input logic [31:0] wd);
      logic [1:0] resp;
      wr(a, wd, resp);
      chk($sformatf("bresp %h", a), mem_event_pkg::RESP_OKAY, resp);
   endtask : wc

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rdat;
      logic [1:0] resp;
      rd(a, rdat, resp);
      chk($sformatf("rdata %h", a), exp, rdat);
      chk($sformatf("rresp %h", a), mem_event_pkg::RESP_OKAY, resp);
   endtask : rc

   // One-cycle hardware event on the three source inputs
   task automatic ev(input logic [8:0] n, input logic [1:0] f, input logic [31:0] m);
      @(posedge core_clk);
      nmi_event <= n;
      flash_done <= f;
      mem_error_event <= m;
      @(posedge core_clk);
      nmi_event <= '0;
      flash_done <= '0;
      mem_error_event <= '0;
   endtask : ev

   // Outputs follow a flag change by one more registered stage
   task automatic settle();
      repeat (2) @(posedge core_clk);
   endtask : settle

   initial
   begin
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int i = 5; i <= 17; i++)
         rc(8'(i * 4), 32'h0000_0000);
      $display("test reset values done");
      wc(mem_event_pkg::NMI_SET_OFF, 32'hffff_ffff);
      rc(mem_event_pkg::NMI_STAT_OFF, 32'h0000_01ff);
      rc(mem_event_pkg::NMI_SET_OFF, 32'h0000_0000);
      chk("nmi_req", 1'b0, nmi_req);
      wc(mem_event_pkg::NMI_CTRL_OFF, 32'h0000_0100);
      settle();
      chk("nmi_req", 1'b1, nmi_req);
      wc(mem_event_pkg::NMI_CLR_OFF, 32'h0000_0000);
      rc(mem_event_pkg::NMI_STAT_OFF, 32'h0000_01ff);
      wc(mem_event_pkg::NMI_CLR_OFF, 32'h0000_0100);
      rc(mem_event_pkg::NMI_STAT_OFF, 32'h0000_00ff);
      settle();
      chk("nmi_req", 1'b0, nmi_req);
      wc(mem_event_pkg::NMI_CLR_OFF, 32'h0000_01ff);
      ev(9'h080, 2'b00, 32'h0);
      rc(mem_event_pkg::NMI_STAT_OFF, 32'h0000_0080);
      $display("test nmi flags done");
      wc(mem_event_pkg::IRQ_EN_OFF, 32'hffff_ffff);
      rc(mem_event_pkg::IRQ_EN_OFF, 32'h0000_0003);
      wc(mem_event_pkg::IRQ_STAT_OFF, 32'h0000_0003);
      rc(mem_event_pkg::IRQ_STAT_OFF, 32'h0000_0000);
      ev(9'h000, 2'b01, 32'h0);
      rc(mem_event_pkg::IRQ_STAT_OFF, 32'h0000_0001);
      chk("flash_done_irq", 2'b01, flash_done_irq);
      wc(mem_event_pkg::IRQ_CLR_OFF, 32'h0000_0000);
      rc(mem_event_pkg::IRQ_STAT_OFF, 32'h0000_0001);
      wc(mem_event_pkg::IRQ_CLR_OFF, 32'h0000_0001);
      rc(mem_event_pkg::IRQ_STAT_OFF, 32'h0000_0000);
      wc(mem_event_pkg::IRQ_SET_OFF, 32'h0000_0002);
      rc(mem_event_pkg::IRQ_STAT_OFF, 32'h0000_0002);
      chk("flash_done_irq", 2'b10, flash_done_irq);
      wc(mem_event_pkg::IRQ_EN_OFF, 32'h0000_0001);
      settle();
      chk("flash_done_irq", 2'b00, flash_done_irq);
      rc(mem_event_pkg::IRQ_SET_OFF, 32'h0000_0000);
      $display("test done interrupts done");
      ev(9'h000, 2'b00, 32'hffff_ffff);
      rc(mem_event_pkg::MERR_STAT_OFF, 32'h0007_07ff);
      wc(mem_event_pkg::MERR_CLR_OFF, 32'h0000_000f);
      rc(mem_event_pkg::MERR_STAT_OFF, 32'h0007_07f0);
      wc(mem_event_pkg::MERR_CLR_OFF, 32'h0007_0700);
      rc(mem_event_pkg::MERR_STAT_OFF, 32'h0000_00f0);
      wc(mem_event_pkg::MERR_SET_OFF, 32'h0001_0001);
      rc(mem_event_pkg::MERR_STAT_OFF, 32'h0001_00f1);
      $display("test memory errors done");
      rd(mem_event_pkg::EVT_STAT_OFF, d, r);
      wc(mem_event_pkg::EVT_MASK_OFF, 32'h0000_0001);
      ev(9'h000, 2'b10, 32'h0);
      settle();
      chk("event_irq", 1'b0, event_irq);
      ev(9'h000, 2'b00, 32'h0000_0200);
      settle();
      chk("event_irq", 1'b1, event_irq);
      rc(mem_event_pkg::EVT_STAT_OFF, 32'h0000_0003);
      settle();
      chk("event_irq", 1'b0, event_irq);
      rc(mem_event_pkg::EVT_STAT_OFF, 32'h0000_0000);
      $display("test summary interrupt done");
      wr(8'h80, 32'h0000_0001, r);
      chk("bresp 80", mem_event_pkg::RESP_SLVERR, r);
      rd(8'h80, d, r);
      chk("rdata 80", 32'h0000_0000, d);
      chk("rresp 80", mem_event_pkg::RESP_SLVERR, r);
      $display("test unmapped access done");
      end_of_test();
   end
endmodule : mem_event_regs_test
